//--- verilog/serial_rx.sv
// asynchronous serial receiver with buffer, auto-baud and wake on break
`timescale 1ns/1ps
`include "serial_rx_regs.svh"

////////////////////////////////////////////////////////////////////////////
// first-word-fall-through buffer, valid/ready on both sides
module rx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word written
  output logic out_valid, // oldest word present
  input wire logic out_ready, // consumer pops
  output logic [WIDTH-1:0] out_data // oldest word
);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_r; // write pointer
  logic [AW-1:0] rd_r; // read pointer
  logic [AW:0] cnt_r; // words held
  logic push; // accepted write
  logic pop; // accepted read

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_r];

  // storage writes carry no reset, only pointers and fill level need one
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module serial_rx
  import serial_rx_pkg::*;
(
  input wire logic clk, // system clock, 125 MHz
  input wire logic nrst, // sync reset, active low
  input wire logic receive_line, // serial input pin
  input wire rx_ctrl_type ctrl, // firmware configuration
  input wire rx_strobe_type stb, // firmware strobes
  output logic receive_flag, // character or event pending
  output logic receive_irq, // flag gated by irq enable
  output logic [7:0] receive_data, // byte from last data read
  output logic receive_ninth, // ninth bit of oldest character
  output logic frame_error_flag, // stop error of oldest
  output logic overrun_error_flag, // overrun seen
  output logic autobaud_enable, // auto-baud in progress
  output logic autobaud_overflow_flag, // rate counter overflowed
  output logic wake_on_break_enable, // wake armed
  output logic receiver_idle_status, // no character in progress
  output logic [15:0] baud_divisor // current divisor
);
  rx_state_type state_r; // receiver state
  logic sync1_r; // synchroniser first stage
  logic sync2_r; // synchroniser second stage
  logic line_q_r; // previous synchronised level
  logic fall; // line went low
  logic rise; // line went high
  logic [22:0] cnt_r; // bit timer
  logic [22:0] period; // cycles per bit
  logic [3:0] idx_r; // bits sampled
  logic [8:0] shift_r; // receive shift register
  logic done; // character ended this cycle
  logic async_on; // asynchronous mode active
  logic rx_on; // normal reception allowed
  rx_word_type word; // completed character
  logic accept; // character qualifies for buffer
  logic in_ready; // buffer has room
  logic out_valid; // buffer holds a character
  rx_word_type head; // oldest character
  logic pop; // firmware read of data
  logic event_r; // wake or auto-baud flag
  logic [15:0] div_r; // divisor register
  logic [2:0] abd_edges_r; // rising edges seen in auto-baud
  logic [9:0] abd_pre_r; // auto-baud prescale counter
  logic [15:0] abd_cnt_r; // auto-baud rate counter
  logic [9:0] abd_span; // cycles per rate count
  logic abd_done; // fifth rising edge reached

  // bit period from divisor and speed selects
  function automatic logic [22:0] bit_cycles(input logic hs,
                                             input logic wide,
                                             input logic [15:0] d);
    logic [22:0] presc;
    logic [22:0] n;
    presc = `RX_PRESC_SLOW;
    if (hs && wide) begin
      presc = `RX_PRESC_FAST;
    end else if (hs || wide) begin
      presc = `RX_PRESC_MID;
    end
    n = wide ? {7'h00, d} : {15'h0000, d[7:0]};
    bit_cycles = 23'(presc * (n + 23'h00_0001));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign async_on = ctrl.port_enable && !ctrl.sync_mode_select;
  // receive path idles in sleep, wake or auto-baud
  assign rx_on = async_on && ctrl.continuous_receive_enable
                 && !ctrl.sleep_mode
                 && !wake_on_break_enable
                 && !autobaud_enable;
  assign period = bit_cycles(ctrl.high_speed_baud_select,
                             ctrl.wide_divisor_select, div_r);
  assign fall = line_q_r && !sync2_r;
  assign rise = !line_q_r && sync2_r;
  assign pop = stb.data_read && out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, idle level high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      line_q_r <= 1'b1;
    end else begin
      sync1_r <= receive_line;
      sync2_r <= sync1_r;
      line_q_r <= sync2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive sequencer; half a bit after the start edge, then whole bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= RX_IDLE;
      cnt_r <= '0;
      idx_r <= '0;
      shift_r <= '0;
    end else if (!rx_on) begin
      state_r <= RX_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        RX_IDLE: begin
          cnt_r <= '0;
          idx_r <= '0;
          if (fall) begin
            state_r <= RX_START;
          end
        end
        RX_START: begin
          cnt_r <= cnt_r + 23'h00_0001;
          if (cnt_r == (period >> 1)) begin
            cnt_r <= '0;
            // a glitch shorter than half a bit is not a start
            state_r <= sync2_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          cnt_r <= cnt_r + 23'h00_0001;
          if (cnt_r == period - 23'h00_0001) begin
            cnt_r <= '0;
            shift_r <= {sync2_r, shift_r[8:1]};
            idx_r <= idx_r + 4'h1;
            if (idx_r == (ctrl.nine_bit_receive_select ? 4'h8 : 4'h7)) begin
              state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          cnt_r <= cnt_r + 23'h00_0001;
          if (cnt_r == period - 23'h00_0001) begin
            state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  assign done = rx_on && state_r == RX_STOP
                && cnt_r == period - 23'h00_0001;

  ////////////////////////////////////////////////////////////////////////////
  // character assembly and buffer admission
  always_comb begin
    word.frame_err = !sync2_r;
    if (ctrl.nine_bit_receive_select) begin
      word.ninth_bit = shift_r[8];
      word.data = shift_r[7:0];
    end else begin
      word.ninth_bit = 1'b0;
      word.data = shift_r[8:1];
    end
  end

  // nine-bit address mode drops characters with ninth bit clear
  assign accept = done && !overrun_error_flag
                  && !(ctrl.address_detect_enable
                       && ctrl.nine_bit_receive_select
                       && !word.ninth_bit);

  rx_fifo #(
    .WIDTH($bits(rx_word_type)),
    .DEPTH(`RX_FIFO_DEPTH),
    .AW(`RX_FIFO_AW)
  ) rx_fifo_i (
    .clk(clk),
    .nrst(nrst),
    .in_valid(accept),
    .in_ready(in_ready),
    .in_data(word),
    .out_valid(out_valid),
    .out_ready(stb.data_read),
    .out_data(head)
  );

  ////////////////////////////////////////////////////////////////////////////
  // overrun: set wins, cleared only by dropping continuous enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      overrun_error_flag <= 1'b0;
    end else if (accept && !in_ready) begin
      overrun_error_flag <= 1'b1;
    end else if (!ctrl.continuous_receive_enable) begin
      overrun_error_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data read returns the oldest byte and pops it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      receive_data <= '0;
    end else if (pop) begin
      receive_data <= head.data;
    end
  end

  // status of the oldest character
  always_ff @(posedge clk) begin
    if (!nrst) begin
      receive_ninth <= 1'b0;
      frame_error_flag <= 1'b0;
    end else begin
      receive_ninth <= out_valid && head.ninth_bit;
      frame_error_flag <= out_valid && head.frame_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flag for wake and auto-baud; a new event beats the read clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_r <= 1'b0;
    end else if ((wake_on_break_enable && fall)
                 || abd_done) begin
      event_r <= 1'b1;
    end else if (stb.data_read) begin
      event_r <= 1'b0;
    end
  end

  // flag and interrupt follow buffer content and events
  always_ff @(posedge clk) begin
    if (!nrst) begin
      receive_flag <= 1'b0;
      receive_irq <= 1'b0;
    end else begin
      receive_flag <= out_valid || event_r;
      receive_irq <= (out_valid || event_r) && ctrl.receive_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake on break; works in sleep since only the pin edge is needed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wake_on_break_enable <= 1'b0;
    end else if (!async_on) begin
      wake_on_break_enable <= 1'b0;
    end else if (stb.wake_set) begin
      wake_on_break_enable <= 1'b1;
    end else if (stb.wake_clear) begin
      wake_on_break_enable <= 1'b0;
    end else if (wake_on_break_enable && rise && event_r) begin
      // first rising edge after the wake ends the break
      wake_on_break_enable <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto-baud: count from rising edge one to five of a 0x55 character
  assign abd_span = 10'(`ABD_SPAN_BITS * period[22:0] / (period[22:0]
                    / ((ctrl.high_speed_baud_select
                        && ctrl.wide_divisor_select) ? `RX_PRESC_FAST
                       : (ctrl.high_speed_baud_select
                          || ctrl.wide_divisor_select) ? `RX_PRESC_MID
                       : `RX_PRESC_SLOW)));
  assign abd_done = autobaud_enable && rise
                    && abd_edges_r == `ABD_LAST_EDGE;

  // edge count and rate counter
  always_ff @(posedge clk) begin
    if (!nrst || !autobaud_enable || ctrl.sleep_mode) begin
      abd_edges_r <= '0;
      abd_pre_r <= '0;
      abd_cnt_r <= '0;
    end else begin
      if (rise) begin
        abd_edges_r <= abd_edges_r + 3'h1;
      end
      if (abd_edges_r != 3'h0) begin
        abd_pre_r <= abd_pre_r + 10'h001;
        if (abd_pre_r == abd_span - 10'h001) begin
          abd_pre_r <= '0;
          abd_cnt_r <= abd_cnt_r + 16'h0001;
        end
      end
    end
  end

  // enable: firmware sets or aborts, fifth edge ends it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      autobaud_enable <= 1'b0;
    end else if (abd_done || stb.autobaud_clear) begin
      autobaud_enable <= 1'b0;
    end else if (stb.autobaud_set && async_on) begin
      autobaud_enable <= 1'b1;
    end
  end

  // overflow: set wins; clear refused while auto-baud still enabled
  always_ff @(posedge clk) begin
    if (!nrst) begin
      autobaud_overflow_flag <= 1'b0;
    end else if (autobaud_enable && abd_edges_r != 3'h0
                 && abd_cnt_r == 16'hFFFF
                 && abd_pre_r == abd_span - 10'h001) begin
      autobaud_overflow_flag <= 1'b1;
    end else if (stb.overflow_clear && !autobaud_enable) begin
      autobaud_overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divisor: firmware write or a clean auto-baud result
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_r <= `RX_DIV_RESET;
    end else if (abd_done && !autobaud_overflow_flag) begin
      // the tick landing on the fifth edge still belongs to the count
      div_r <= abd_cnt_r - 16'h0001
               + 16'(abd_pre_r == abd_span - 10'h001);
    end else if (stb.divisor_write) begin
      div_r <= stb.divisor_value;
    end
  end

  // visible copies of internal state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      baud_divisor <= `RX_DIV_RESET;
      receiver_idle_status <= 1'b1;
    end else begin
      baud_divisor <= div_r;
      receiver_idle_status <= (state_r == RX_IDLE);
    end
  end
endmodule

//--- verilog/serial_rx_regs.svh
// constants of the asynchronous serial receiver
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH
// prescale of the bit period per divisor count
`define RX_PRESC_FAST 23'h00_0004
`define RX_PRESC_MID 23'h00_0010
`define RX_PRESC_SLOW 23'h00_0040
// auto-baud measures eight bit times between rising edges one and five
`define ABD_SPAN_BITS 10'h008
`define ABD_LAST_EDGE 3'h4
// receive buffer geometry
`define RX_FIFO_DEPTH 8
`define RX_FIFO_AW 3
// divisor value after reset
`define RX_DIV_RESET 16'h0000
`endif

//--- verilog/serial_rx_pkg.sv
// types shared by the asynchronous serial receiver
package serial_rx_pkg;
  // one received character as held in the buffer
  typedef struct packed {
    logic frame_err;
    logic ninth_bit;
    logic [7:0] data;
  } rx_word_type;
  // static configuration from firmware
  typedef struct packed {
    logic port_enable;
    logic sync_mode_select;
    logic nine_bit_receive_select;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic receive_irq_enable;
    logic high_speed_baud_select;
    logic wide_divisor_select;
    logic sleep_mode;
  } rx_ctrl_type;
  // one-cycle firmware strobes
  typedef struct packed {
    logic divisor_write;
    logic [15:0] divisor_value;
    logic autobaud_set;
    logic autobaud_clear;
    logic overflow_clear;
    logic wake_set;
    logic wake_clear;
    logic data_read;
  } rx_strobe_type;
  // receiver states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;
endpackage

//--- verification/serial_rx_assertions.sv
// port-level checks of the asynchronous serial receiver
`timescale 1ns/1ps
module serial_rx_checker
  import serial_rx_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic receive_line, // serial pin
  input wire rx_ctrl_type ctrl, // configuration
  input wire rx_strobe_type stb, // strobes
  input wire logic receive_flag, // pending flag
  input wire logic receive_irq, // gated flag
  input wire logic [7:0] receive_data, // byte of last read
  input wire logic receive_ninth, // ninth bit of oldest
  input wire logic overrun_error_flag, // overrun seen
  input wire logic autobaud_enable, // auto-baud running
  input wire logic autobaud_overflow_flag, // rate counter wrapped
  input wire logic wake_on_break_enable, // wake armed
  input wire logic receiver_idle_status // no character in flight
);
  logic rx_ok; // configuration lets a character start
  assign rx_ok = ctrl.port_enable && !ctrl.sync_mode_select &&
    ctrl.continuous_receive_enable && !ctrl.sleep_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  AST_RX_GATED: assert property (
    $fell(receiver_idle_status) |-> $past(rx_ok))
    else $error("character started while reception disabled");
  AST_WAKE_FLAG: assert property (
    wake_on_break_enable && $fell(receive_line) |-> ##[1:8] receive_flag)
    else $error("wake event raised no flag");
  AST_WAKE_END: assert property (
    $fell(wake_on_break_enable) && !$past(stb.wake_clear) |-> receive_line)
    else $error("wake enable dropped while line low");
  AST_ABD_END: assert property (
    $fell(autobaud_enable) && !$past(stb.autobaud_clear) &&
    !$past(stb.autobaud_clear, 2) |-> ##[0:3] receive_flag)
    else $error("auto-baud ended without flag");
  AST_OVF_HOLD: assert property (
    autobaud_overflow_flag && autobaud_enable |=> autobaud_overflow_flag)
    else $error("overflow cleared while auto-baud enabled");
  AST_OVR_STICKY: assert property (
    overrun_error_flag && ctrl.continuous_receive_enable |=>
    overrun_error_flag)
    else $error("overrun dropped while enabled");
  AST_OVR_CLEAR: assert property (
    !ctrl.continuous_receive_enable [*3] |-> !overrun_error_flag)
    else $error("overrun kept with receive disabled");
  AST_IRQ_OFF: assert property (
    !ctrl.receive_irq_enable [*2] |-> !receive_irq)
    else $error("interrupt while masked");
  AST_ADDR_NINTH: assert property (
    $rose(receive_flag) && ctrl.address_detect_enable &&
    !wake_on_break_enable && !$past(autobaud_enable) |->
    ##[0:2] receive_ninth)
    else $error("address mode ninth bit not one");
  AST_DATA_HOLD: assert property (
    !$past(stb.data_read) && !$past(stb.data_read, 2) |->
    $stable(receive_data))
    else $error("read data changed without a read");
endmodule
bind serial_rx serial_rx_checker serial_rx_checker_i (.clk, .nrst,
  .receive_line, .ctrl, .stb, .receive_flag, .receive_irq, .receive_data,
  .receive_ninth, .overrun_error_flag, .autobaud_enable,
  .autobaud_overflow_flag, .wake_on_break_enable, .receiver_idle_status);

//--- verification/serial_tx_model.sv
// remote asynchronous sender driving the receive line
`timescale 1ns/1ps
module serial_tx_model (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic go, // send one frame
  input wire logic [15:0] bits, // line levels, first in bit 0
  input wire logic [4:0] nb, // levels in the frame
  input wire logic [7:0] per, // clock cycles per level
  output logic line, // receive line, idle high
  output logic busy // frame in flight
);
  logic [15:0] sh_r; // levels still to send
  logic [4:0] n_r; // levels left
  logic [7:0] c_r; // cycles left in this level
  ////////////////////////////////////////////////////////////////////////////
  // frame shifter; line rests high between frames like a pulled-up pin
  always_ff @(posedge clk) begin
    if (!nrst) begin
      line <= 1'b1;
      busy <= 1'b0;
    end else if (go && !busy) begin
      sh_r <= bits;
      n_r <= nb;
      c_r <= per - 8'h01;
      busy <= 1'b1;
      line <= bits[0];
    end else if (busy) begin
      if (c_r != 8'h00) begin
        c_r <= c_r - 8'h01;
      end else if (n_r == 5'h01) begin
        busy <= 1'b0;
        line <= 1'b1;
      end else begin
        sh_r <= sh_r >> 1;
        line <= sh_r[1];
        n_r <= n_r - 5'h01;
        c_r <= per - 8'h01;
      end
    end
  end
endmodule

//--- verification/serial_rx_test.sv
// self-checking bench of the asynchronous serial receiver
`timescale 1ns/1ps
module serial_rx_test;
  import serial_rx_pkg::*;
  logic clk, nrst, receive_line, go, busy; // clock, reset, sender
  rx_ctrl_type ctrl; // configuration
  rx_strobe_type stb, s; // strobes and the one being built
  logic [15:0] tbits, baud_divisor; // frame levels, divisor
  logic [4:0] tnb; // frame length
  logic [7:0] tper, receive_data; // level length, read byte
  logic receive_flag, receive_irq, receive_ninth, frame_error_flag;
  logic overrun_error_flag, autobaud_enable, autobaud_overflow_flag;
  logic wake_on_break_enable, receiver_idle_status;
  logic [31:0] seed; // random source
  logic [7:0] hist [8]; // bytes expected back out of the buffer
  int errors, cmp_count, cyc;
  // port on, continuous receive, irq enable, fast baud, wide divisor
  localparam rx_ctrl_type base_cfg = 9'h12e;
  localparam logic [8:0] wt [4] = '{9'h1c3, 9'h012, 9'h134, 9'h056};
  localparam logic [8:0] mt [5] = '{9'h020, 9'h100, 9'h080, 9'h001, 9'h008};
  serial_rx serial_rx_i (.clk, .nrst, .receive_line, .ctrl, .stb,
    .receive_flag, .receive_irq, .receive_data, .receive_ninth,
    .frame_error_flag, .overrun_error_flag, .autobaud_enable,
    .autobaud_overflow_flag, .wake_on_break_enable, .receiver_idle_status,
    .baud_divisor);
  serial_tx_model serial_tx_model_i (.clk, .nrst, .go, .bits(tbits),
    .nb(tnb), .per(tper), .line(receive_line), .busy);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cut a hang short; the whole run needs well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      $display("unexpected timeout");
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // line levels of a frame: start low, data lsb first, stop
  function automatic logic [15:0] fr(input logic [8:0] d, input logic n9,
      input logic stp);
    return n9 ? {5'h1f, stp, d, 1'b0} : {6'h3f, stp, d[7:0], 1'b0};
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle strobe, then let the design settle
  task automatic pulse(input rx_strobe_type p);
    @(posedge clk);
    stb <= p;
    @(posedge clk);
    stb <= '0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rd();
    s = '0;
    s.data_read = 1'b1;
    pulse(s);
  endtask
  task automatic cfg(input rx_ctrl_type c);
    @(posedge clk);
    ctrl <= c;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic start_tx(input logic [15:0] b, input logic [4:0] n);
    @(posedge clk);
    tbits <= b;
    tnb <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic finish_tx();
    while (busy) begin
      @(posedge clk);
      #1;
    end
    repeat (6) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    ctrl = '0;
    stb = '0;
    s = '0;
    go = 1'b0;
    tbits = '1;
    tnb = 5'h01;
    tper = 8'h08;
    seed = 32'h4713_77ac;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("idle", 1, receiver_idle_status);
    chk("flag", 0, receive_flag);
    cfg(base_cfg);
    // divisor 1 with prescale 4 gives eight cycles a bit
    s = '0;
    s.divisor_write = 1'b1;
    s.divisor_value = 16'h0001;
    pulse(s);
    chk("divisor", 16'h0001, baud_divisor);
    done("reset");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      start_tx(fr({1'b0, seed[7:0]}, 1'b0, 1'b1), 5'h0a);
      finish_tx();
      chk("flag", 1, receive_flag);
      chk("irq", 1, receive_irq);
      chk("ferr", 0, frame_error_flag);
      rd();
      chk("data", seed[7:0], receive_data);
      chk("flag", 0, receive_flag);
    end
    // stop bit sampled low
    start_tx(fr(9'h0a5, 1'b0, 1'b0), 5'h0a);
    finish_tx();
    chk("ferr", 1, frame_error_flag);
    rd();
    chk("data", 8'ha5, receive_data);
    done("bytes");
    // the two slower prescales: 16 and 64 per count, divisor low byte 1
    for (int m = 0; m < 2; m++) begin
      cfg(base_cfg ^ (m ? 9'h006 : 9'h002));
      tper = m ? 8'h80 : 8'h20;
      seed = lfsr(seed);
      start_tx(fr({1'b0, seed[7:0]}, 1'b0, 1'b1), 5'h0a);
      finish_tx();
      chk("flag", 1, receive_flag);
      rd();
      chk("data", seed[7:0], receive_data);
    end
    tper = 8'h08;
    done("prescale");
    // nine-bit, a rejected word, address detect on, address detect off
    for (int k = 0; k < 4; k++) begin
      cfg(base_cfg ^ ((k % 3) != 0 ? 9'h050 : 9'h040));
      start_tx(fr(wt[k], 1'b1, 1'b1), 5'h0b);
      finish_tx();
      chk("flag", k != 1, receive_flag);
      chk("ninth", wt[k][8] && k != 1, receive_ninth);
      rd();
      if (k != 1) chk("data", wt[k][7:0], receive_data);
    end
    done("address");
    // fill the buffer until it refuses, then drain it
    cfg(base_cfg);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      if (i < 8) hist[i] = seed[7:0];
      start_tx(fr({1'b0, seed[7:0]}, 1'b0, 1'b1), 5'h0a);
      finish_tx();
    end
    chk("ovr", 1, overrun_error_flag);
    for (int i = 0; i < 8; i++) begin
      rd();
      chk("data", hist[i], receive_data);
    end
    chk("flag", 0, receive_flag);
    chk("ovr", 1, overrun_error_flag);
    cfg(base_cfg ^ 9'h020);
    chk("ovr", 0, overrun_error_flag);
    done("overrun");
    // each blocking setting, then irq masked with reception still on
    for (int k = 0; k < 5; k++) begin
      cfg(base_cfg ^ mt[k]);
      start_tx(fr(9'h03c, 1'b0, 1'b1), 5'h0a);
      finish_tx();
      chk("flag", k == 4, receive_flag);
      chk("irq", 0, receive_irq);
      rd();
    end
    done("gating");
    cfg(base_cfg);
    s = '0;
    s.autobaud_set = 1'b1;
    pulse(s);
    tper = 8'h10;
    start_tx(fr(9'h055, 1'b0, 1'b1), 5'h0a);
    finish_tx();
    chk("abd_en", 0, autobaud_enable);
    chk("flag", 1, receive_flag);
    chk("abd_ovf", 0, autobaud_overflow_flag);
    // sixteen cycles a bit at prescale four is a divisor of three
    chk("divisor", 16'h0003, baud_divisor);
    rd();
    chk("flag", 0, receive_flag);
    pulse(s);
    s = '0;
    s.autobaud_clear = 1'b1;
    pulse(s);
    chk("abd_en", 0, autobaud_enable);
    tper = 8'h08;
    s = '0;
    s.divisor_write = 1'b1;
    s.divisor_value = 16'h0001;
    pulse(s);
    done("autobaud");
    // a long all-zero break, then a non-zero character, both asleep
    for (int j = 0; j < 2; j++) begin
      chk("idle", 1, receiver_idle_status);
      s = '0;
      s.wake_set = 1'b1;
      pulse(s);
      cfg(base_cfg ^ 9'h001);
      start_tx(j ? fr(9'h0f0, 1'b0, 1'b1) : 16'h0000,
        j ? 5'h0a : 5'h0d);
      repeat (12) @(posedge clk);
      #1;
      chk("flag", 1, receive_flag);
      chk("wake", 1, wake_on_break_enable);
      finish_tx();
      chk("wake", 0, wake_on_break_enable);
      cfg(base_cfg);
      rd();
      chk("flag", 0, receive_flag);
    end
    done("wake");
    end_sim();
  end
endmodule
